// >>> nvw_map.svh
// register offsets, field positions, unlock keys and timing counts of the nvm write controller
`ifndef NVW_MAP_SVH
`define NVW_MAP_SVH

// printed offsets are not all multiples of four: they are indexes, byte address = 4 * index
`define NVW_IDX_IRQ_FLAGS2 9'h00d
`define NVW_IDX_IRQ_EN2 9'h08d
`define NVW_IDX_DATA_LO 9'h10c
`define NVW_IDX_ADDR_LO 9'h10d
`define NVW_IDX_DATA_HI 9'h10e
`define NVW_IDX_ADDR_HI 9'h10f
`define NVW_IDX_CTRL1 9'h18c
`define NVW_IDX_UNLOCK 9'h18d
`define NVW_IDX_PROT 9'h18e

// control register fields
`define NVW_CTRL_PGM_SEL 7
`define NVW_CTRL_WERR 3
`define NVW_CTRL_WEN 2
`define NVW_CTRL_WSTART 1
`define NVW_CTRL_RSTART 0
// irq flag / enable position
`define NVW_IRQ_DONE_BIT 4
// protection register fields
`define NVW_PROT_DATA 0
`define NVW_PROT_PGM 1
`define NVW_PROT_REG_LO 2

`define NVW_UNLOCK_KEY1 8'h55
`define NVW_UNLOCK_KEY2 8'haa
`define NVW_BLOCK_WORDS 4

`define NVW_CLK_HZ 50000000
`define NVW_PWRT_MS 72
`define NVW_PWRT_CYC ((`NVW_CLK_HZ / 1000) * `NVW_PWRT_MS)
`define NVW_EE_WRITE_CYC 200
`define NVW_PGM_WRITE_CYC 400

`endif

// >>> nvw_pkg.sv
// types shared by the nvm write controller files
package nvw_pkg;
	typedef enum logic [1:0] {NVW_IDLE, NVW_EE_BUSY, NVW_PGM_BUSY} nvw_state_t;
	typedef enum logic [1:0] {NVW_UL_NONE, NVW_UL_KEY1, NVW_UL_ARMED} nvw_unlock_t;
	typedef struct packed {
		logic pgm;
		logic [12:0] addr;
		logic [13:0] data;
	} nvw_wreq_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [8:0] idx;
		logic [7:0] wdata;
	} nvw_acc_t;
endpackage

// >>> nvw_unlock.sv
// unlock sequence tracker: 55h then aah on the unlock port, then the start bit
`timescale 1ns/100ps
`default_nettype none
`include "nvw_map.svh"
module nvw_unlock
	import nvw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic acc_valid,
	input wire logic acc_unlock,
	input wire logic [7:0] acc_wdata,
	input wire logic consume,
	output logic armed
);
	nvw_unlock_t st_reg;
	nvw_unlock_t st_next;
	wire logic key1_hit = acc_valid && acc_unlock && acc_wdata == `NVW_UNLOCK_KEY1;
	wire logic key2_hit = acc_valid && acc_unlock && acc_wdata == `NVW_UNLOCK_KEY2;

	// any other write breaks the sequence [RQ3]
	always_comb begin
		st_next = st_reg;
		if (consume) begin
			st_next = NVW_UL_NONE;
		end else if (acc_valid) begin
			case (st_reg)
				NVW_UL_NONE: st_next = key1_hit ? NVW_UL_KEY1 : NVW_UL_NONE;
				NVW_UL_KEY1: st_next = key2_hit ? NVW_UL_ARMED : (key1_hit ? NVW_UL_KEY1 : NVW_UL_NONE);
				default: st_next = NVW_UL_NONE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= NVW_UL_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign armed = st_reg == NVW_UL_ARMED;
endmodule
`default_nettype wire

// >>> nvw_timer.sv
// down counter: loads a cycle count, reports done for one cycle at zero
`timescale 1ns/100ps
`default_nettype none
module nvw_timer #(
	parameter int W = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			done <= 1'b0;
		end else begin
			done <= cnt_reg == W'(1) && !load;
			if (load) begin
				cnt_reg <= count;
			end else if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - W'(1);
			end
		end
	end
	assign busy = cnt_reg != '0;
endmodule
`default_nettype wire

// >>> nvw_ctrl.sv
// nvm self-write controller with ahb-lite register slave
//
// Contract
// RQ1 - power-up clears write enable; no self-write until software sets it again
// RQ2 - data eeprom writes are blocked while the power-up timer runs
// RQ3 - writes start only with write enable set and unlock sequence completed
// RQ4 - software writes 55h then aah to unlock port, then sets start bit
// RQ5 - software disables global interrupts around the unlock sequence
// RQ6 - program write halts the core; next two instruction slots do not execute
// RQ7 - core is released when program write ends; resumes at third instruction
// RQ8 - flash programs in four-word blocks starting at address with low bits 00
// RQ9 - software increments low address per word; block ends after low bits 11
// RQ10 - program word is data high as upper part, data low as lower byte
// RQ11 - memory select set targets program flash; clear targets data eeprom
// RQ12 - unlock port has no storage; it only accepts the sequence writes
// RQ13 - protected data eeprom still reads and writes normally from the core
// RQ14 - protected data eeprom refuses external access and external program writes
// RQ15 - protected program memory inhibits self-writes to selected regions, external access
// RQ16 - on completion clear start bit, set done flag, interrupt when enabled
// RQ17 - write aborted by reset sets write error flag, readable after reset
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "nvw_map.svh"
module nvw_ctrl
	import nvw_pkg::*;
#(
	parameter int PWRT_CYC = `NVW_PWRT_CYC,
	parameter int EE_CYC = `NVW_EE_WRITE_CYC,
	parameter int PGM_CYC = `NVW_PGM_WRITE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_req,
	input wire logic ext_write,
	input wire logic ext_pgm,
	output logic ext_grant,
	output logic core_stall,
	output logic irq_done,
	output logic nvm_wr_valid,
	output nvw_wreq_t nvm_wr
);
	// ************************************************
	// bus address phase capture
	// ************************************************
	nvw_acc_t acc_reg;
	wire logic ap_take = hsel && hready && htrans[1] && haddr[1:0] == 2'b00;
	wire logic [8:0] ap_idx = haddr[10:2];
	wire logic dp_wr = acc_reg.valid && acc_reg.write;
	wire logic [7:0] wb = hwdata[7:0];

	function automatic logic hit(input logic [8:0] idx, input logic [8:0] reg_idx);
		hit = idx == reg_idx;
	endfunction

	wire logic wr_dlo = dp_wr && hit(acc_reg.idx, `NVW_IDX_DATA_LO);
	wire logic wr_alo = dp_wr && hit(acc_reg.idx, `NVW_IDX_ADDR_LO);
	wire logic wr_dhi = dp_wr && hit(acc_reg.idx, `NVW_IDX_DATA_HI);
	wire logic wr_ahi = dp_wr && hit(acc_reg.idx, `NVW_IDX_ADDR_HI);
	wire logic wr_ctl = dp_wr && hit(acc_reg.idx, `NVW_IDX_CTRL1);
	wire logic wr_ulk = dp_wr && hit(acc_reg.idx, `NVW_IDX_UNLOCK);
	wire logic wr_flg = dp_wr && hit(acc_reg.idx, `NVW_IDX_IRQ_FLAGS2);
	wire logic wr_ien = dp_wr && hit(acc_reg.idx, `NVW_IDX_IRQ_EN2);
	wire logic wr_prt = dp_wr && hit(acc_reg.idx, `NVW_IDX_PROT);

	// ************************************************
	// registers
	// ************************************************
	logic [7:0] data_lo_reg;
	logic [7:0] addr_lo_reg;
	logic [5:0] data_hi_reg;
	logic [4:0] addr_hi_reg;
	logic pgm_sel_reg;
	logic wen_reg;
	logic wstart_reg;
	logic werr_reg;
	logic done_flag_reg;
	logic done_ien_reg;
	logic [3:0] prot_reg;
	logic wip_reg;
	nvw_state_t state_reg;
	nvw_state_t state_next;
	logic [1:0] blk_cnt_reg;

	// ************************************************
	// unlock tracker and write timers
	// ************************************************
	logic armed;
	logic start_req;
	nvw_unlock #() u_unlock (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.acc_valid(dp_wr),
		.acc_unlock(wr_ulk),
		.acc_wdata(wb),
		.consume(start_req),
		.armed(armed)
	);

	logic pwrt_busy;
	nvw_timer #(.W(32)) u_pwrt (
		.clk_sys(clk_sys),
		.rst_n(por_n),
		.load(1'b0),
		.count('0),
		.busy(),
		.done()
	);
	// power-up timer: counter from power-on reset release, stops at PWRT_CYC
	logic [31:0] pwrt_cnt_reg;
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			pwrt_cnt_reg <= '0;
		end else if (pwrt_busy) begin
			pwrt_cnt_reg <= pwrt_cnt_reg + 32'h1;
		end
	end
	assign pwrt_busy = pwrt_cnt_reg < 32'(PWRT_CYC);

	logic wt_load;
	logic wt_busy;
	logic wt_done;
	nvw_timer #(.W(16)) u_wtimer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(wt_load),
		.count(pgm_sel_reg ? 16'(PGM_CYC) : 16'(EE_CYC)),
		.busy(wt_busy),
		.done(wt_done)
	);

	// ************************************************
	// start decision
	// ************************************************
	wire logic [12:0] full_addr = {addr_hi_reg, addr_lo_reg};
	wire logic [1:0] prot_region = prot_reg[`NVW_PROT_REG_LO +: 2];
	// region field: 00 none, 01 lowest sixteenth, 10 lower half, 11 everything
	wire logic region_blocked = prot_reg[`NVW_PROT_PGM] && (
		prot_region == 2'b11 ||
		(prot_region == 2'b10 && !full_addr[12]) ||
		(prot_region == 2'b01 && full_addr[12:9] == 4'h0)); // [RQ15]
	// program words go in order inside an aligned block; a stray start is refused [RQ8]
	wire logic blk_misaligned = addr_lo_reg[1:0] != blk_cnt_reg;
	wire logic start_set = wr_ctl && wb[`NVW_CTRL_WSTART];
	assign start_req = start_set && state_reg == NVW_IDLE;
	wire logic start_ok = start_req && wen_reg && armed // [RQ3]
		&& !(!pgm_sel_reg && pwrt_busy) // [RQ2]
		&& !(pgm_sel_reg && region_blocked) // [RQ11] [RQ15]
		&& !(pgm_sel_reg && blk_misaligned); // [RQ8]
	// last word of a four-word block: low address bits 11 [RQ8]
	wire logic blk_last = addr_lo_reg[1:0] == 2'(`NVW_BLOCK_WORDS - 1);

	always_comb begin
		state_next = state_reg;
		wt_load = 1'b0;
		case (state_reg)
			NVW_IDLE: begin
				if (start_ok) begin
					state_next = pgm_sel_reg ? NVW_PGM_BUSY : NVW_EE_BUSY;
					wt_load = 1'b1;
				end
			end
			NVW_EE_BUSY: begin
				if (wt_done) begin
					state_next = NVW_IDLE;
				end
			end
			NVW_PGM_BUSY: begin
				if (wt_done) begin
					state_next = NVW_IDLE;
				end
			end
			default: state_next = NVW_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= NVW_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************
	// software registers
	// ************************************************
	wire logic done_evt = state_reg != NVW_IDLE && wt_done;

	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			data_lo_reg <= 8'h00;
			addr_lo_reg <= 8'h00;
			data_hi_reg <= 6'h00;
			addr_hi_reg <= 5'h00;
			prot_reg <= 4'h0;
		end else begin
			// address and data freeze while busy, so block position cannot slip
			if (wr_dlo && state_reg == NVW_IDLE) begin
				data_lo_reg <= wb;
			end
			if (wr_alo && state_reg == NVW_IDLE) begin
				addr_lo_reg <= wb;
			end
			if (wr_dhi && state_reg == NVW_IDLE) begin
				data_hi_reg <= wb[5:0];
			end
			if (wr_ahi && state_reg == NVW_IDLE) begin
				addr_hi_reg <= wb[4:0];
			end
			// protection may change at any time; it gates the next start and the external grant
			if (wr_prt) begin
				prot_reg <= wb[3:0];
			end
		end
	end

	// write-in-progress survives a warm reset to flag the abort
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			wip_reg <= 1'b0;
			werr_reg <= 1'b0;
		end else begin
			wip_reg <= state_next != NVW_IDLE;
			if (wip_reg && !rst_n) begin
				werr_reg <= 1'b1; // [RQ17]
			end else if (wr_ctl && !wb[`NVW_CTRL_WERR]) begin
				werr_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pgm_sel_reg <= 1'b0;
			wen_reg <= 1'b0; // [RQ1]
			wstart_reg <= 1'b0;
			done_flag_reg <= 1'b0;
			done_ien_reg <= 1'b0;
			blk_cnt_reg <= 2'b00;
		end else begin
			if (wr_ctl && state_reg == NVW_IDLE) begin
				pgm_sel_reg <= wb[`NVW_CTRL_PGM_SEL]; // [RQ11]
				wen_reg <= wb[`NVW_CTRL_WEN];
			end
			if (done_evt) begin
				wstart_reg <= 1'b0; // [RQ16]
			end else if (start_ok) begin
				wstart_reg <= 1'b1;
			end
			// set wins over a software clear in the same cycle
			if (done_evt) begin
				done_flag_reg <= 1'b1; // [RQ16]
			end else if (wr_flg) begin
				done_flag_reg <= wb[`NVW_IRQ_DONE_BIT];
			end
			if (wr_ien) begin
				done_ien_reg <= wb[`NVW_IRQ_DONE_BIT];
			end
			if (done_evt && state_reg == NVW_PGM_BUSY) begin
				blk_cnt_reg <= blk_last ? 2'b00 : blk_cnt_reg + 2'b01; // [RQ9]
			end
		end
	end

	// ************************************************
	// memory write request, core stall, external port
	// ************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			nvm_wr_valid <= 1'b0;
			nvm_wr <= '0;
			core_stall <= 1'b0;
			irq_done <= 1'b0;
			ext_grant <= 1'b0;
		end else begin
			nvm_wr_valid <= start_ok;
			if (start_ok) begin
				nvm_wr.pgm <= pgm_sel_reg;
				nvm_wr.addr <= full_addr;
				nvm_wr.data <= {data_hi_reg, data_lo_reg}; // [RQ10]
			end
			// stall from start through completion; the two next slots are lost [RQ6] [RQ7]
			core_stall <= (start_ok && pgm_sel_reg) || (state_reg == NVW_PGM_BUSY && !wt_done);
			irq_done <= (done_flag_reg || done_evt) && done_ien_reg; // [RQ16]
			// internal data eeprom access is never gated by protection [RQ13]
			ext_grant <= ext_req && !prot_reg[`NVW_PROT_PGM]
				&& !(prot_reg[`NVW_PROT_DATA] && (!ext_pgm || ext_write)); // [RQ14] [RQ15]
		end
	end

	// ************************************************
	// bus data phase
	// ************************************************
	wire logic [7:0] ctl_rd = {pgm_sel_reg, 3'b000, werr_reg, wen_reg, wstart_reg, 1'b0};
	wire logic [7:0] rd_sel =
		hit(ap_idx, `NVW_IDX_DATA_LO) ? data_lo_reg :
		hit(ap_idx, `NVW_IDX_ADDR_LO) ? addr_lo_reg :
		hit(ap_idx, `NVW_IDX_DATA_HI) ? {2'b00, data_hi_reg} :
		hit(ap_idx, `NVW_IDX_ADDR_HI) ? {3'b000, addr_hi_reg} :
		hit(ap_idx, `NVW_IDX_CTRL1) ? ctl_rd :
		hit(ap_idx, `NVW_IDX_IRQ_FLAGS2) ? {3'b000, done_flag_reg, 4'h0} :
		hit(ap_idx, `NVW_IDX_IRQ_EN2) ? {3'b000, done_ien_reg, 4'h0} :
		hit(ap_idx, `NVW_IDX_PROT) ? {4'h0, prot_reg} :
		8'h00; // unlock port reads zero: no storage [RQ12]

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
			hrdata <= 32'h0000_0000;
		end else begin
			if (hready) begin
				acc_reg.valid <= ap_take;
				acc_reg.write <= hwrite;
				acc_reg.idx <= ap_idx;
				acc_reg.wdata <= 8'h00;
				hrdata <= (ap_take && !hwrite) ? {24'h000000, rd_sel} : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> nvw_ctrl_props.sv
// assertion checker of the nvm write controller ports
`timescale 1ns/100ps
`default_nettype none
module nvw_ctrl_props
	import nvw_pkg::*;
#(
	parameter int PWRT_CYC = 3600000,
	parameter int PGM_CYC = 400
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic ext_req,
	input wire logic ext_grant,
	input wire logic core_stall,
	input wire logic nvm_wr_valid,
	input wire nvw_wreq_t nvm_wr
);
	logic [31:0] pwr_cnt_reg;
	logic [31:0] stall_cnt_reg;
	// saturates so a long run cannot wrap back under the limit
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n)
			pwr_cnt_reg <= 32'h0;
		else if (pwr_cnt_reg != 32'hffffffff)
			pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			stall_cnt_reg <= 32'h0;
		else
			stall_cnt_reg <= core_stall ? stall_cnt_reg + 32'h1 : 32'h0;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	pwrt_block_a: assert property (nvm_wr_valid && !nvm_wr.pgm |-> pwr_cnt_reg >= 32'(PWRT_CYC))
		else $error("data write started under power-up timer");
	stall_start_a: assert property (nvm_wr_valid && nvm_wr.pgm |-> core_stall)
		else $error("program write without core stall");
	stall_cause_a: assert property ($rose(core_stall) |-> nvm_wr_valid && nvm_wr.pgm)
		else $error("core stall without program write");
	stall_len_a: assert property ($fell(core_stall) |->
		stall_cnt_reg >= 32'(PGM_CYC - 2) && stall_cnt_reg <= 32'(PGM_CYC + 2))
		else $error("core stall length wrong");
	ee_no_stall_a: assert property (nvm_wr_valid && !nvm_wr.pgm |-> !core_stall)
		else $error("data write stalled the core");
	one_start_a: assert property (nvm_wr_valid |=> !nvm_wr_valid)
		else $error("write start longer than one cycle");
	no_restart_a: assert property (nvm_wr_valid |-> !$past(core_stall))
		else $error("write started during program write");
	req_hold_a: assert property (core_stall && $past(core_stall) |-> $stable(nvm_wr))
		else $error("write word changed during program write");
	grant_cause_a: assert property (ext_grant |-> $past(ext_req))
		else $error("external grant without request");
endmodule
`default_nettype wire

// >>> nvw_mem_model.sv
// behavioural nvm model: keeps the last write the controller launches and counts every one
`timescale 1ns/100ps
`default_nettype none
module nvw_mem_model
	import nvw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nvm_wr_valid,
	input wire nvw_wreq_t nvm_wr,
	output var nvw_wreq_t last,
	output var int count
);
	// the count must start known, or every compare against it fails
	initial begin
		count = 0;
	end
	always @(posedge clk_sys) begin
		if (nvm_wr_valid) begin
			last <= nvm_wr;
			count <= count + 1;
		end
	end
endmodule
`default_nettype wire

// >>> tb_nvw_ctrl.sv
// self-checking testbench of the nvm write controller
`timescale 1ns/100ps
`default_nettype none
`include "nvw_map.svh"
module tb_nvw_ctrl
	import nvw_pkg::*;
;
	localparam logic [8:0] c_ctl = `NVW_IDX_CTRL1, c_unl = `NVW_IDX_UNLOCK, c_prt = `NVW_IDX_PROT;
	localparam logic [8:0] c_dlo = `NVW_IDX_DATA_LO, c_dhi = `NVW_IDX_DATA_HI;
	localparam logic [8:0] c_alo = `NVW_IDX_ADDR_LO, c_ahi = `NVW_IDX_ADDR_HI;
	localparam logic [8:0] c_flg = `NVW_IDX_IRQ_FLAGS2, c_ien = `NVW_IDX_IRQ_EN2;
	logic clk_sys = 0, rst_n = 0, por_n = 0, hwrite = 0, ext_req = 0, ext_write = 0, ext_pgm = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, q;
	wire hreadyout, hresp, ext_grant, core_stall, irq_done, nvm_wr_valid;
	wire logic [31:0] hrdata;
	wire nvw_wreq_t nvm_wr;
	nvw_wreq_t last;
	int cnt, fail_count = 0, comparisons = 0, st = 0, s0;
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (core_stall) st <= st + 1;
	nvw_ctrl #(.PWRT_CYC(100)) i_nvw_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ext_req(ext_req), .ext_write(ext_write), .ext_pgm(ext_pgm),
		.ext_grant(ext_grant), .core_stall(core_stall), .irq_done(irq_done),
		.nvm_wr_valid(nvm_wr_valid), .nvm_wr(nvm_wr));
	nvw_mem_model i_nvw_mem_model (.clk_sys(clk_sys), .nvm_wr_valid(nvm_wr_valid),
		.nvm_wr(nvm_wr), .last(last), .count(cnt));
	// ****************
	// bus access tasks
	// ****************
	task x(input logic wr, input logic [8:0] i, input logic [7:0] d);
		htrans <= 2'h2;
		haddr <= {21'h0, i, 2'h0};
		hwrite <= wr;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		q = hrdata;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, s, e);
		end
	endtask
	// enable first: the start write must find write enable already set
	// no interrupt source is modelled, so nothing can split the sequence
	task go(input logic [7:0] c);
		x(1, c_ctl, c);
		x(1, c_unl, 8'h55);
		x(1, c_unl, 8'haa);
		x(1, c_ctl, c | 8'h02);
	endtask
	task wt;
		for (int k = 0; k < 300; k++) begin
			x(0, c_ctl, 8'h00);
			if (q[1] === 1'b0) break;
		end
		repeat (2) @(posedge clk_sys);
	endtask
	task print_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		fail_count++;
		print_verdict;
	end
	// **********
	// test steps
	// **********
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1;
		por_n <= 1;
		@(posedge clk_sys);
		x(0, c_ctl, 0); chk(q & 32'h06, 0);
		x(1, c_unl, 8'h55); x(0, c_unl, 0); chk(q, 0);
		chk(hresp, 0);
		x(0, 9'h1ff, 0); chk(q, 0);
		x(1, c_ahi, 0); x(1, c_dhi, 0); go(8'h04); chk(cnt, 0);
		repeat (100) @(posedge clk_sys);
		x(1, c_ctl, 0); x(1, c_unl, 8'h55); x(1, c_unl, 8'haa); x(1, c_ctl, 8'h02);
		x(1, c_ctl, 8'h04); x(1, c_unl, 8'haa); x(1, c_unl, 8'h55); x(1, c_ctl, 8'h06);
		x(1, c_ctl, 8'h04); x(1, c_unl, 8'h55); x(1, c_dlo, 0); x(1, c_unl, 8'haa);
		x(1, c_ctl, 8'h06); x(0, c_ctl, 0); chk(q[1], 0); chk(cnt, 0);
		x(1, c_ien, 8'h10); x(1, c_alo, 8'h12); x(1, c_dlo, 8'h34); go(8'h04); wt;
		chk(last, {1'b0, 13'h0012, 14'h0034}); chk(cnt, 1);
		x(0, c_flg, 0); chk(q[4], 1); chk(irq_done, 1);
		x(1, c_flg, 0); repeat (2) @(posedge clk_sys); chk(irq_done, 0);
		x(1, c_prt, 8'h01); x(1, c_dlo, 8'h56); go(8'h04); wt;
		chk(last[13:0], 14'h0056); chk(cnt, 2);
		ext_req <= 1; ext_write <= 1; repeat (2) @(posedge clk_sys);
		chk(ext_grant, 0);
		ext_pgm <= 1; repeat (2) @(posedge clk_sys); chk(ext_grant, 0);
		x(1, c_prt, 0); repeat (2) @(posedge clk_sys); chk(ext_grant, 1);
		ext_req <= 0;
		x(1, c_alo, 8'h10);
		x(1, c_prt, 8'h0e); x(1, c_ahi, 8'h01); go(8'h84); repeat (4) @(posedge clk_sys);
		chk(cnt, 2); x(0, c_ctl, 0); chk(q[1], 0);
		x(1, c_prt, 8'h06);
		go(8'h84);
		x(1, c_prt, 8'h0a);
		go(8'h84);
		repeat (4) @(posedge clk_sys);
		chk(cnt, 2);
		x(1, c_prt, 0);
		x(1, c_alo, 8'h05);
		go(8'h84);
		repeat (4) @(posedge clk_sys);
		chk(cnt, 2);
		x(1, c_alo, 8'h04);
		for (int i = 0; i < 4; i++) begin
			x(1, c_dlo, 8'(8'h40 + i)); x(1, c_dhi, 8'h2a); s0 = st; go(8'h84); wt;
			chk(st != s0, 1); chk(core_stall, 0);
			chk(last, {1'b1, 13'(13'h0104 + i), 6'h2a, 8'(8'h40 + i)});
			x(1, c_ctl, 0); x(1, c_alo, 8'(8'h05 + i));
		end
		chk(cnt, 6);
		x(1, c_ahi, 0); go(8'h04); repeat (20) @(posedge clk_sys);
		rst_n <= 0; repeat (2) @(posedge clk_sys); rst_n <= 1; @(posedge clk_sys);
		x(0, c_ctl, 0); chk(q & 32'h0c, 32'h08);
		print_verdict;
	end
endmodule
bind nvw_ctrl nvw_ctrl_props #(.PWRT_CYC(PWRT_CYC), .PGM_CYC(PGM_CYC)) i_nvw_ctrl_props (
	.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n), .ext_req(ext_req),
	.ext_grant(ext_grant), .core_stall(core_stall), .nvm_wr_valid(nvm_wr_valid),
	.nvm_wr(nvm_wr));
`default_nettype wire
